/* File: ivm_core_model.sv */
// processor core stand-in that acknowledges presented vectors
`timescale 1ns/1ps
`default_nettype none

module ivm_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // request from the mapper and ack delay
  input wire ivm_pkg::ivm_core_req_type core_i,
  input wire logic [3:0] delay_i,
  // acknowledge back
  output logic ack_o
);
  logic [3:0] wait_r;

  // one-cycle ack after delay_i cycles of a standing request
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      wait_r <= 4'h0;
    end
    else if (core_i.req && !ack_o && wait_r >= delay_i)
    begin
      ack_o <= 1'b1;
      wait_r <= 4'h0;
    end
    else
    begin
      ack_o <= 1'b0;
      wait_r <= core_i.req ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

`default_nettype wire

/* File: ivm_defs.svh */
// constants for the reset and vector table mapper
`ifndef IVM_DEFS_SVH
`define IVM_DEFS_SVH

`define IVM_RESET_ADDR 24'h000000
`define IVM_PRI_BASE 24'h000004
`define IVM_ALT_OFFSET 24'h000100
`define IVM_IRQ_VEC_BASE 8'h08
`define IVM_MAX_SRC 128
`define IVM_TRAP_IMPL 8'h1e
`define IVM_TRAP_IPL 4'h8

`define IVM_REG_CTRL 12'h000
`define IVM_REG_TEST 12'h004
`define IVM_REG_TRAP 12'h008
`define IVM_REG_EVT_STAT 12'h00c
`define IVM_REG_EVT_MASK 12'h010
`define IVM_REG_FLAG_BASE 12'h040
`define IVM_REG_EN_BASE 12'h080
`define IVM_REG_PRIO_BASE 12'h100

`define IVM_CTRL_ALT_BIT 0
`define IVM_TEST_VEC_LSB 0
`define IVM_TEST_ILR_LSB 8
`define IVM_EVT_ACK_BIT 0
`define IVM_EVT_TRAP_BIT 1
`define IVM_PRIO_FIELD_STRIDE 4

`define IVM_TRAP1_ADDR 24'h000006
`define IVM_INT0_ADDR 24'h000014
`define IVM_PMP_VEC 8'h35
`define IVM_PMP_ADDR 24'h00006e
`define IVM_ICN_VEC 8'h1b
`define IVM_ICN_ADDR 24'h00003a
`define IVM_KSTORE_VEC 8'h40
`define IVM_KSTORE_ADDR 24'h000084
`define IVM_RTC_VEC 8'h46
`define IVM_RTC_ADDR 24'h000090

`endif

/* File: ivm_pkg.sv */
// types and address helpers for the reset and vector table mapper
`default_nettype none
`include "ivm_defs.svh"

package ivm_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD_MEM = 2'b01,
    BUS_RD_OUT = 2'b10
  } ivm_bus_st_type;

  typedef struct packed {
    logic req;
    logic [7:0] vec;
    logic [23:0] addr;
    logic [3:0] ipl;
  } ivm_core_req_type;

  typedef struct packed {
    logic [7:0] vec;
    logic [3:0] ilr;
  } ivm_test_type;

  typedef struct packed {
    ivm_bus_st_type bus_st;
    logic ph_vld;
    logic ph_wr;
    logic [11:0] ph_addr;
    logic hready;
    logic [31:0] hrdata;
    logic alt_sel;
    logic [7:0] trap_flags;
    logic [127:0] flags;
    logic [127:0] enables;
    logic [1:0] evt_stat;
    logic [1:0] evt_mask;
    logic irq;
    ivm_test_type test;
    ivm_core_req_type core;
    logic pc_load;
    logic [4:0] scan_idx;
    logic [4:0] rd_idx;
    logic rd_vld;
    logic best_vld;
    logic [6:0] best_n;
    logic [2:0] best_p;
    logic cand_vld;
    logic [6:0] cand_n;
    logic [2:0] cand_p;
  } ivm_state_type;

  // table word address of a vector, primary or alternate
  function automatic logic [23:0] ivm_vec_addr(input logic [7:0] vec, input logic alt);
    ivm_vec_addr = `IVM_PRI_BASE + {15'h0000, vec, 1'b0} + (alt ? `IVM_ALT_OFFSET : 24'h000000);
  endfunction

  // vector number of a peripheral request
  function automatic logic [7:0] ivm_irq_vec(input logic [6:0] n);
    ivm_irq_vec = {1'b0, n} + `IVM_IRQ_VEC_BASE;
  endfunction

endpackage

`default_nettype wire

/* File: ivm_prio_mem.sv */
// priority word store with registered read data
`timescale 1ns/1ps
`default_nettype none

module ivm_prio_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 16,
  parameter int AW = 5
) (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // read port
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rdata_r;

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_r <= mem_r[raddr_i];
  end

  assign rdata_o = rdata_r;

endmodule

`default_nettype wire

/* File: ivm_vector_mapper.sv */
// reset entry, vector lookup and request arbitration with ahb-lite registers
// Operation
// - reset clears registers except the priority words, forces program counter zero
// - execution starts at address zero after reset
// - eight trap vectors from word four, step two
// - alternate table address is primary plus 100h
// - request n uses vector n+8, base+2*vector
// - flag bit n%16, priority field per 4
// - key-store done: request 56, vector 64
// - parallel master port: request 45, vector 53
// - realtime calendar: request 62, vector 70
// - input change notify: request 19, vector 27
// - select bit switches all fetches to alternate
// - lower vector address wins among equals
// - flags set by hardware, cleared by software
// - accepted request latches vector and level
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ivm_defs.svh"

module ivm_vector_mapper #(
  parameter int NUM_SRC = 118,
  parameter int NUM_PWORD = 30
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // request sources
  input wire logic [NUM_SRC-1:0] irq_i,
  input wire logic [7:0] trap_i,
  // processor core
  input wire logic [3:0] cpu_ipl_i,
  input wire logic core_ack_i,
  output ivm_pkg::ivm_core_req_type core_o,
  output logic pc_load_o,
  output logic [23:0] pc_addr_o,
  // interrupt
  output logic irq_o
);

  localparam logic [127:0] SRC_MASK = {128{1'b1}} >> (`IVM_MAX_SRC - NUM_SRC);
  localparam logic [4:0] LAST_PWORD = 5'(NUM_PWORD - 1);

  ivm_pkg::ivm_state_type st_r;
  ivm_pkg::ivm_state_type st_nxt;
  logic mem_we;
  logic [4:0] mem_waddr;
  logic [15:0] mem_wdata;
  logic [4:0] mem_raddr;
  logic [15:0] mem_rdata;
  logic trap_hit;
  logic [7:0] trap_vec;
  logic pend_ok;
  logic ack;
  ivm_prio_mem #(
    .DEPTH(32),
    .WIDTH(16),
    .AW(5)
  ) u_prio_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );
  always_comb
  begin
    logic [6:0] n;
    logic [2:0] p;
    logic b_vld;
    logic [6:0] b_n;
    logic [2:0] b_p;
    logic [11:0] a;
    n = 7'h00;
    p = 3'h0;
    b_vld = 1'b0;
    b_n = 7'h00;
    b_p = 3'h0;
    a = st_r.ph_addr;
    st_nxt = st_r;
    mem_we = 1'b0;
    mem_waddr = a[6:2];
    mem_wdata = hwdata_i[15:0];
    mem_raddr = st_r.scan_idx;
    st_nxt.pc_load = 1'b0;
    if (st_r.ph_vld && st_r.ph_wr && st_r.hready)
    begin
      if (a == `IVM_REG_CTRL)
      begin
        st_nxt.alt_sel = hwdata_i[`IVM_CTRL_ALT_BIT];
      end
      else if (a == `IVM_REG_TRAP)
      begin
        st_nxt.trap_flags = hwdata_i[7:0];
      end
      else if (a == `IVM_REG_EVT_MASK)
      begin
        st_nxt.evt_mask = hwdata_i[1:0];
      end
      else if ({a[11:5], 5'h00} == `IVM_REG_FLAG_BASE)
      begin
        st_nxt.flags[{a[4:2], 4'h0} +: 16] = hwdata_i[15:0];
      end
      else if ({a[11:5], 5'h00} == `IVM_REG_EN_BASE)
      begin
        st_nxt.enables[{a[4:2], 4'h0} +: 16] = hwdata_i[15:0];
      end
      else if ({a[11:7], 7'h00} == `IVM_REG_PRIO_BASE)
      begin
        mem_we = 1'b1;
      end
    end
    case (st_r.bus_st)
      ivm_pkg::BUS_RD_MEM:
      begin
        mem_raddr = a[6:2];
        st_nxt.bus_st = ivm_pkg::BUS_RD_OUT;
      end
      ivm_pkg::BUS_RD_OUT:
      begin
        st_nxt.hrdata = 32'h00000000;
        if (a == `IVM_REG_CTRL)
        begin
          st_nxt.hrdata[`IVM_CTRL_ALT_BIT] = st_r.alt_sel;
        end
        else if (a == `IVM_REG_TEST)
        begin
          st_nxt.hrdata[`IVM_TEST_VEC_LSB +: 8] = st_r.test.vec;
          st_nxt.hrdata[`IVM_TEST_ILR_LSB +: 4] = st_r.test.ilr;
        end
        else if (a == `IVM_REG_TRAP)
        begin
          st_nxt.hrdata[7:0] = st_r.trap_flags;
        end
        else if (a == `IVM_REG_EVT_STAT)
        begin
          st_nxt.hrdata[1:0] = st_r.evt_stat;
          st_nxt.evt_stat = 2'b00;
        end
        else if (a == `IVM_REG_EVT_MASK)
        begin
          st_nxt.hrdata[1:0] = st_r.evt_mask;
        end
        else if ({a[11:5], 5'h00} == `IVM_REG_FLAG_BASE)
        begin
          st_nxt.hrdata[15:0] = st_r.flags[{a[4:2], 4'h0} +: 16];
        end
        else if ({a[11:5], 5'h00} == `IVM_REG_EN_BASE)
        begin
          st_nxt.hrdata[15:0] = st_r.enables[{a[4:2], 4'h0} +: 16];
        end
        else if ({a[11:7], 7'h00} == `IVM_REG_PRIO_BASE)
        begin
          st_nxt.hrdata[15:0] = mem_rdata;
        end
        st_nxt.hready = 1'b1;
        st_nxt.bus_st = ivm_pkg::BUS_IDLE;
      end
      default:
      begin
        st_nxt.bus_st = ivm_pkg::BUS_IDLE;
      end
    endcase
    // address phase last, so the idle branch keeps a new read
    st_nxt.ph_vld = 1'b0;
    if (hready_i && hsel_i && htrans_i[1])
    begin
      st_nxt.ph_vld = 1'b1;
      st_nxt.ph_wr = hwrite_i && (hsize_i == 3'b010);
      st_nxt.ph_addr = haddr_i[11:0];
      if (!hwrite_i)
      begin
        st_nxt.hready = 1'b0;
        st_nxt.bus_st = ivm_pkg::BUS_RD_MEM;
      end
    end
    // hardware sets win over software clears
    st_nxt.flags[NUM_SRC-1:0] = st_nxt.flags[NUM_SRC-1:0] | irq_i;
    st_nxt.flags = st_nxt.flags & SRC_MASK;
    st_nxt.enables = st_nxt.enables & SRC_MASK;
    st_nxt.trap_flags = st_nxt.trap_flags | (trap_i & `IVM_TRAP_IMPL);
    st_nxt.rd_vld = (st_r.bus_st != ivm_pkg::BUS_RD_MEM);
    if (st_nxt.rd_vld)
    begin
      st_nxt.rd_idx = st_r.scan_idx;
      st_nxt.scan_idx = (st_r.scan_idx == LAST_PWORD) ? 5'h00 : st_r.scan_idx + 5'h01;
    end
    if (st_r.rd_vld)
    begin
      b_vld = (st_r.rd_idx == 5'h00) ? 1'b0 : st_r.best_vld;
      b_n = st_r.best_n;
      b_p = st_r.best_p;
      for (int k = 0; k < 4; k++)
      begin
        n = {st_r.rd_idx, 2'(k)};
        p = mem_rdata[k * `IVM_PRIO_FIELD_STRIDE +: 3];
        // strict compare keeps the lower vector on a tie
        if ((32'(n) < NUM_SRC) && st_r.flags[n] && st_r.enables[n] &&
            ({1'b0, p} > cpu_ipl_i) && (!b_vld || (p > b_p)))
        begin
          b_vld = 1'b1;
          b_n = n;
          b_p = p;
        end
      end
      st_nxt.best_vld = b_vld;
      st_nxt.best_n = b_n;
      st_nxt.best_p = b_p;
      if (st_r.rd_idx == LAST_PWORD)
      begin
        st_nxt.cand_vld = b_vld;
        st_nxt.cand_n = b_n;
        st_nxt.cand_p = b_p;
      end
    end
    trap_hit = 1'b0;
    trap_vec = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      if (st_r.trap_flags[i] && (`IVM_TRAP_IPL > cpu_ipl_i))
      begin
        trap_hit = 1'b1;
        trap_vec = 8'(i);
      end
    end
    pend_ok = st_r.cand_vld && st_r.flags[st_r.cand_n] && st_r.enables[st_r.cand_n] &&
              ({1'b0, st_r.cand_p} > cpu_ipl_i);
    ack = core_ack_i && st_r.core.req;
    if (trap_hit)
    begin
      st_nxt.core.vec = trap_vec;
      st_nxt.core.ipl = `IVM_TRAP_IPL;
    end
    else
    begin
      st_nxt.core.vec = ivm_pkg::ivm_irq_vec(st_r.cand_n);
      st_nxt.core.ipl = {1'b0, st_r.cand_p};
    end
    st_nxt.core.addr = ivm_pkg::ivm_vec_addr(st_nxt.core.vec, st_r.alt_sel);
    st_nxt.core.req = (trap_hit || pend_ok) && !ack;
    if (ack)
    begin
      st_nxt.test.vec = st_r.core.vec;
      st_nxt.test.ilr = st_r.core.ipl;
      if (st_r.core.vec < `IVM_IRQ_VEC_BASE)
      begin
        st_nxt.evt_stat[`IVM_EVT_TRAP_BIT] = 1'b1;
      end
      else
      begin
        st_nxt.evt_stat[`IVM_EVT_ACK_BIT] = 1'b1;
      end
    end
    st_nxt.irq = |(st_nxt.evt_stat & st_nxt.evt_mask);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
      st_r.hready <= 1'b1;
      st_r.pc_load <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign hrdata_o = st_r.hrdata;
  assign hreadyout_o = st_r.hready;
  assign hresp_o = 1'b0;
  assign core_o = st_r.core;
  assign pc_load_o = st_r.pc_load;
  assign pc_addr_o = `IVM_RESET_ADDR;
  assign irq_o = st_r.irq;

  sequence s_read_addr;
    hready_i && hsel_i && htrans_i[1] && !hwrite_i;
  endsequence
  sequence s_read_done;
    !hreadyout_o ##1 !hreadyout_o ##1 hreadyout_o;
  endsequence
  a_read_timing: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_addr |=> s_read_done)
    else $error("read data phase not two wait states");
  a_reset_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    pc_load_o |-> (pc_addr_o == `IVM_RESET_ADDR) && !core_o.req ##1 !pc_load_o)
    else $error("reset entry not at address zero");
  a_trap_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    core_o.req && (core_o.vec == 8'h01) |-> core_o.addr == (`IVM_TRAP1_ADDR | {15'h0, core_o.addr[8], 8'h00}))
    else $error("trap vector address wrong");
  a_alt_select: assert property (@(posedge clk_i) disable iff (rst_i)
    core_o.req && $stable(st_r.alt_sel) |-> core_o.addr[8] == st_r.alt_sel)
    else $error("alternate table select not honoured");
  a_int0_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    core_o.req && (core_o.vec == 8'h08) |-> core_o.addr[7:0] == `IVM_INT0_ADDR)
    else $error("external interrupt zero address wrong");
  a_kstore_map: assert property (@(posedge clk_i) disable iff (rst_i)
    core_o.req && (core_o.vec == `IVM_KSTORE_VEC) |-> core_o.addr[7:0] == `IVM_KSTORE_ADDR)
    else $error("key store vector address wrong");
  a_pmp_map: assert property (@(posedge clk_i) disable iff (rst_i)
    core_o.req && (core_o.vec == `IVM_PMP_VEC) |-> core_o.addr[7:0] == `IVM_PMP_ADDR)
    else $error("parallel port vector address wrong");
  a_rtc_map: assert property (@(posedge clk_i) disable iff (rst_i)
    core_o.req && (core_o.vec == `IVM_RTC_VEC) |-> core_o.addr[7:0] == `IVM_RTC_ADDR)
    else $error("calendar vector address wrong");
  a_icn_map: assert property (@(posedge clk_i) disable iff (rst_i)
    core_o.req && (core_o.vec == `IVM_ICN_VEC) |-> core_o.addr[7:0] == `IVM_ICN_ADDR)
    else $error("input change vector address wrong");
  a_trap_first: assert property (@(posedge clk_i) disable iff (rst_i)
    core_o.req && (core_o.vec >= `IVM_IRQ_VEC_BASE) |-> !$past(trap_hit))
    else $error("peripheral presented over pending trap");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_i[0] |=> st_r.flags[0])
    else $error("request flag not set");
  a_test_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    core_ack_i && core_o.req |=> (st_r.test.vec == $past(core_o.vec)) && !core_o.req)
    else $error("test register not latched on accept");
  a_ipl_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    core_o.req |-> core_o.ipl > $past(cpu_ipl_i))
    else $error("request presented at or below cpu level");
endmodule

`default_nettype wire

/* File: tb.sv */
// self-checking bench for the reset and vector table mapper
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [117:0] irq = '0;
  logic [7:0] trap = 8'h00;
  logic [3:0] ipl = 4'h0;
  logic [3:0] dly = 4'h0;
  logic ack;
  logic pc_load;
  logic [23:0] pc_addr;
  logic irq_out;
  logic alt;
  logic [31:0] q;
  ivm_pkg::ivm_core_req_type core;
  int fails = 0;
  int check_count = 0;
  int n_tab [5] = '{0, 19, 45, 56, 62};
  logic [7:0] v_tab [5] = '{8'h08, 8'h1b, 8'h35, 8'h40, 8'h46};
  logic [23:0] a_tab [5] = '{24'h000014, 24'h00003a, 24'h00006e, 24'h000084, 24'h000090};

  always #2.5 clk = ~clk;

  ivm_vector_mapper dut_u (
    .clk_i(clk), .rst_i(rst), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .irq_i(irq),
    .trap_i(trap), .cpu_ipl_i(ipl), .core_ack_i(ack), .core_o(core),
    .pc_load_o(pc_load), .pc_addr_o(pc_addr), .irq_o(irq_out)
  );

  ivm_core_model core_u (
    .clk_i(clk), .rst_i(rst), .core_i(core), .delay_i(dly), .ack_o(ack)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // wait for an edge with hready high
  task automatic hwait();
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (hready !== 1'b1 && i < 20);
    if (hready !== 1'b1)
    begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    hwait();
    htrans <= 2'b00;
    hwdata <= d;
    hwait();
    q = hrdata;
  endtask

  task automatic wreq(input logic [7:0] v, input logic [23:0] a, input logic [3:0] p);
    int i;
    i = 0;
    while (core.req !== 1'b1 && i < 200)
    begin
      @(posedge clk);
      i++;
    end
    chk({31'h0, core.req}, 32'h1);
    if (core.req !== 1'b1)
    begin
      end_of_test();
    end
    chk({core.vec, core.addr}, {v, a});
    chk({28'h0, core.ipl}, {28'h0, p});
    repeat (8) @(posedge clk);
  endtask

  task automatic arm(input int n);
    bus(1'b1, 12'h100 + 12'(4 * (n / 4)), 32'h3 << (4 * (n % 4)));
    bus(1'b1, 12'h080 + 12'(4 * (n / 16)), 32'h1 << (n % 16));
    irq[n] <= 1'b1;
    @(posedge clk);
    irq[n] <= 1'b0;
  endtask

  task automatic disarm(input int n);
    bus(1'b1, 12'h040 + 12'(4 * (n / 16)), 32'h0);
    bus(1'b1, 12'h080 + 12'(4 * (n / 16)), 32'h0);
    bus(1'b0, 12'h040 + 12'(4 * (n / 16)), 32'h0);
    chk(q, 32'h0);
    repeat (4) @(posedge clk);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    chk({7'h0, pc_load, pc_addr}, 32'h01000000);
    chk({core.vec, core.addr}, 32'h0);
    rst <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk({7'h0, pc_load, pc_addr}, 32'h0);
    for (int w = 0; w < 30; w++)
      bus(1'b1, 12'h100 + 12'(4 * w), 32'h0);
    bus(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 12'hffc, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    for (int s = 0; s < 2; s++)
    begin
      alt = s[0];
      dly <= 4'(3 * s);
      bus(1'b1, 12'h000, {31'h0, alt});
      for (int k = 0; k < 5; k++)
      begin
        arm(n_tab[k]);
        bus(1'b0, 12'h040 + 12'(4 * (n_tab[k] / 16)), 32'h0);
        chk(q, 32'h1 << (n_tab[k] % 16));
        wreq(v_tab[k], a_tab[k] + {15'h0, alt, 8'h0}, 4'h3);
        chk({31'h0, irq_out}, 32'h0);
        bus(1'b0, 12'h004, 32'h0);
        chk(q, {20'h0, 4'h3, v_tab[k]});
        disarm(n_tab[k]);
      end
      for (int t = 1; t < 5; t++)
      begin
        trap <= 8'(1 << t);
        @(posedge clk);
        trap <= 8'h00;
        wreq(8'(t), 24'(4 + 2 * t) + {15'h0, alt, 8'h0}, 4'h8);
        bus(1'b1, 12'h008, 32'h0);
        repeat (4) @(posedge clk);
      end
      $display("test vectors done");
    end
    ipl <= 4'h3;
    arm(45);
    arm(19);
    repeat (80) @(posedge clk);
    chk({31'h0, core.req}, 32'h0);
    ipl <= 4'h2;
    wreq(8'h1b, 24'h00013a, 4'h3);
    disarm(19);
    disarm(45);
    ipl <= 4'h0;
    $display("test priority done");
    bus(1'b0, 12'h00c, 32'h0);
    bus(1'b1, 12'h010, 32'h1);
    arm(0);
    wreq(8'h08, 24'h000114, 4'h3);
    disarm(0);
    chk({31'h0, irq_out}, 32'h1);
    bus(1'b0, 12'h00c, 32'h0);
    chk(q, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_out}, 32'h0);
    bus(1'b0, 12'h010, 32'h0);
    chk(q, 32'h1);
    $display("test interrupt done");
    rst <= 1'b1;
    @(posedge clk);
    chk({31'h0, pc_load}, 32'h1);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test second reset done");
    end_of_test();
  end
endmodule

`default_nettype wire
